// [rtl/mtl_consts.vh]
`ifndef MTL_CONSTS_VH
`define MTL_CONSTS_VH

// register byte offsets
`define MTL_OFF_REV_LIMIT   12'h000
`define MTL_OFF_LIMIT_CFG   12'h004
`define MTL_OFF_CONTROL     12'h008
`define MTL_OFF_DEV_WARN    12'h00C
`define MTL_OFF_SON_WARN    12'h010
`define MTL_OFF_TORQUE_LIM  12'h014
`define MTL_OFF_GAIN        12'h018
`define MTL_OFF_GEAR_NUM    12'h01C
`define MTL_OFF_GEAR_DEN    12'h020
`define MTL_OFF_TURNS       12'h024
`define MTL_OFF_DEVIATION   12'h028
`define MTL_OFF_EXPECTED    12'h02C
`define MTL_OFF_IRQ_STATUS  12'h030
`define MTL_OFF_IRQ_MASK    12'h034
`define MTL_OFF_STATE       12'h038

// field positions
`define MTL_CFG_ENABLE_BIT  0
`define MTL_CFG_CYCSEL_BIT  4
`define MTL_CTL_CLEAR_BIT   0
`define MTL_IRQ_DEV_BIT     0
`define MTL_IRQ_SON_BIT     1
`define MTL_IRQ_WRAP_BIT    2

// reset values, ranges and scale factors
`define MTL_REV_LIMIT_RST   16'h0000
`define MTL_LIMIT_CFG_RST   16'h0000
`define MTL_REV_LIMIT_MAX   16'h7530
`define MTL_TURNS_MAX       16'h7FFF
`define MTL_TURNS_MIN       16'h8000
`define MTL_SEC_PER_MIN     32'h0000003C
`define MTL_DEV_WARN_RST    32'h7FFFFFFF
`define MTL_TORQUE_LIM_RST  16'h7FFF

`endif

// [rtl/mtl_turn_counter.v]
`timescale 1ns/100ps
`default_nettype none

`include "mtl_consts.vh"

// multi-turn counter with optional revolution limit
module mtl_turn_counter
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clear,
  input  wire        step_fwd,
  input  wire        step_rev,
  input  wire        limit_on,
  input  wire        cyclic,
  input  wire [15:0] limit,
  output reg  [15:0] turns_reg,
  output reg  [31:0] accum_reg,
  output reg         wrap_reg
);

  reg  [15:0] turns_next;
  reg         wrap_next;

  always @*
  begin
    turns_next = turns_reg;
    wrap_next  = 1'b0;
    if (clear)
      turns_next = 16'h0000;
    else if (limit_on && step_fwd && !step_rev)
    begin
      if (turns_reg >= limit - 16'h0001)
      begin
        turns_next = 16'h0000;
        wrap_next  = 1'b1;
      end
      else
        turns_next = turns_reg + 16'h0001;
    end
    else if (limit_on && step_rev && !step_fwd)
    begin
      if (turns_reg == 16'h0000 || turns_reg >= limit)
      begin
        turns_next = limit - 16'h0001;
        wrap_next  = 1'b1;
      end
      else
        turns_next = turns_reg - 16'h0001;
    end
    else if (step_fwd && !step_rev)
    begin
      turns_next = turns_reg + 16'h0001;
      wrap_next  = (turns_reg == `MTL_TURNS_MAX);
    end
    else if (step_rev && !step_fwd)
    begin
      turns_next = turns_reg - 16'h0001;
      wrap_next  = (turns_reg == `MTL_TURNS_MIN);
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      turns_reg <= 16'h0000;
      accum_reg <= 32'h00000000;
      wrap_reg  <= 1'b0;
    end
    else
    begin
      turns_reg <= turns_next;
      wrap_reg  <= wrap_next;
      if (clear)
        accum_reg <= 32'h00000000;
      else if (step_fwd && !step_rev && !cyclic)
        accum_reg <= accum_reg + 32'h00000001;
      else if (step_rev && !step_fwd && !cyclic)
        accum_reg <= accum_reg - 32'h00000001;
    end
  end

endmodule

`default_nettype wire

// [rtl/mtl_tracker.v]
// How it works
// - unlimited turn count is signed, -32768 to +32767.
// - forward past +32767 wraps to -32768.
// - revolution limit register takes 0 to 30000, resets to zero.
// - with the limit active the count wraps at the limit.
// - limit applies only while its enable bit is 1.
// - cyclic select 0 reports the turn count repeating per limit cycle.
// - cyclic select 1 reports the accumulated turn position.
// - limit function works only with an absolute encoder.
// - deviation is commanded minus actual position.
// - expected deviation is rpm/60 times resolution/gain times gear ratio.
// - deviation above warning threshold in position control stops the motor.
// - separate deviation threshold is checked at servo-on.
// - output torque is clamped to the torque limit.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

`include "mtl_consts.vh"

module mtl_tracker
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        enc_absolute,
  input  wire        enc_step_fwd,
  input  wire        enc_step_rev,
  input  wire [31:0] cmd_position,
  input  wire [31:0] act_position,
  input  wire [15:0] motor_speed_rpm,
  input  wire [15:0] encoder_resolution,
  input  wire        position_control,
  input  wire        servo_on_req,
  input  wire [15:0] torque_request,
  output reg  [15:0] torque_out,
  output reg  [15:0] multiturn_count_monitor,
  output reg  [31:0] position_feedback,
  output reg         motor_enable,
  output wire        irq
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {enc_absolute, enc_step_fwd, enc_step_rev};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire abs_sync = pin_sync_reg[2];
  wire fwd_sync = pin_sync_reg[1];
  wire rev_sync = pin_sync_reg[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [15:0] revolution_upper_limit_reg;
  reg [15:0] turn_limit_function_config_reg;
  reg [31:0] deviation_warning_threshold_reg;
  reg [31:0] servo_on_deviation_threshold_reg;
  reg [15:0] torque_limit_reg;
  reg [15:0] position_loop_gain_reg;
  reg [15:0] gear_ratio_numerator_reg;
  reg [15:0] gear_ratio_denominator_reg;
  reg [2:0]  irq_status_reg;
  reg [2:0]  irq_mask_reg;
  reg        clear_pulse_reg;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a[1:0] == 2'b00) && (a <= `MTL_OFF_STATE);
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_known(paddr);

  wire turn_limit_enable              = turn_limit_function_config_reg[`MTL_CFG_ENABLE_BIT];
  wire position_feedback_cycle_select = turn_limit_function_config_reg[`MTL_CFG_CYCSEL_BIT];

  // ---------------------------------------------------------------
  // position deviation and supervision
  // ---------------------------------------------------------------
  // commanded minus actual
  wire [31:0] deviation     = cmd_position - act_position;
  wire [31:0] deviation_abs = deviation[31] ? (32'h00000000 - deviation) : deviation;

  wire dev_event = position_control && (deviation_abs > deviation_warning_threshold_reg);

  reg servo_on_d_reg;
  // check only on the servo-on edge
  wire son_event = servo_on_req && !servo_on_d_reg &&
                   (deviation_abs > servo_on_deviation_threshold_reg);

  wire [2:0] wrap_vec;
  wire [2:0] evt = {wrap_vec[0], son_event, dev_event};
  reg        fault_reg;

  // ---------------------------------------------------------------
  // expected steady deviation, registered to keep timing short
  // ---------------------------------------------------------------
  // rpm/60 * res/gain * num/den
  reg  [31:0] expected_reg;
  wire [47:0] exp_prod  = {32'h00000000, motor_speed_rpm} * {32'h00000000, encoder_resolution};
  wire [63:0] exp_gear  = {16'h0000, exp_prod} * {48'h000000000000, gear_ratio_numerator_reg};
  wire [63:0] exp_div   = {48'h000000000000, position_loop_gain_reg} *
                          {48'h000000000000, gear_ratio_denominator_reg} *
                          {32'h00000000, `MTL_SEC_PER_MIN};
  wire        exp_ok    = (exp_div != 64'h0000000000000000);
  wire [63:0] exp_quot  = exp_ok ? (exp_gear / exp_div) : 64'h0000000000000000;

  // ---------------------------------------------------------------
  // turn counter
  // ---------------------------------------------------------------
  // absolute encoder only; zero limit means plain wrap
  wire limit_active = turn_limit_enable && abs_sync &&
                      (revolution_upper_limit_reg != 16'h0000);
  wire [15:0] turns;
  wire [31:0] accum;
  wire        wrap_evt;

  assign wrap_vec = {2'b00, wrap_evt};

  mtl_turn_counter u_counter
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (clear_pulse_reg),
    .step_fwd  (fwd_sync),
    .step_rev  (rev_sync),
    .limit_on  (limit_active),
    .cyclic    (!position_feedback_cycle_select),
    .limit     (revolution_upper_limit_reg),
    .turns_reg (turns),
    .accum_reg (accum),
    .wrap_reg  (wrap_evt)
  );

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      revolution_upper_limit_reg       <= `MTL_REV_LIMIT_RST;
      turn_limit_function_config_reg   <= `MTL_LIMIT_CFG_RST;
      deviation_warning_threshold_reg  <= `MTL_DEV_WARN_RST;
      servo_on_deviation_threshold_reg <= `MTL_DEV_WARN_RST;
      torque_limit_reg                 <= `MTL_TORQUE_LIM_RST;
      position_loop_gain_reg           <= 16'h0001;
      gear_ratio_numerator_reg         <= 16'h0001;
      gear_ratio_denominator_reg       <= 16'h0001;
      irq_status_reg                   <= 3'h0;
      irq_mask_reg                     <= 3'h0;
      clear_pulse_reg                  <= 1'b0;
    end
    else
    begin
      clear_pulse_reg <= 1'b0;
      // sticky events: a set in the clear cycle wins
      irq_status_reg <= (irq_status_reg &
                         ~((wr_en && paddr == `MTL_OFF_IRQ_STATUS) ? pwdata[2:0] : 3'h0)) | evt;
      if (wr_en)
      begin
        case (paddr)
          `MTL_OFF_REV_LIMIT:
          begin
            if (pwdata[15:0] <= `MTL_REV_LIMIT_MAX)
              revolution_upper_limit_reg <= pwdata[15:0];
          end
          `MTL_OFF_LIMIT_CFG:  turn_limit_function_config_reg <= pwdata[15:0];
          // host-issued clear of the multi-turn value
          `MTL_OFF_CONTROL:    clear_pulse_reg <= pwdata[`MTL_CTL_CLEAR_BIT];
          `MTL_OFF_DEV_WARN:   deviation_warning_threshold_reg <= pwdata;
          `MTL_OFF_SON_WARN:   servo_on_deviation_threshold_reg <= pwdata;
          `MTL_OFF_TORQUE_LIM: torque_limit_reg <= pwdata[15:0];
          `MTL_OFF_GAIN:       position_loop_gain_reg <= pwdata[15:0];
          `MTL_OFF_GEAR_NUM:   gear_ratio_numerator_reg <= pwdata[15:0];
          `MTL_OFF_GEAR_DEN:   gear_ratio_denominator_reg <= pwdata[15:0];
          `MTL_OFF_IRQ_MASK:   irq_mask_reg <= pwdata[2:0];
          default:             clear_pulse_reg <= 1'b0;
        endcase
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always @*
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      case (paddr)
        `MTL_OFF_REV_LIMIT:  prdata = {16'h0000, revolution_upper_limit_reg};
        `MTL_OFF_LIMIT_CFG:  prdata = {16'h0000, turn_limit_function_config_reg};
        `MTL_OFF_DEV_WARN:   prdata = deviation_warning_threshold_reg;
        `MTL_OFF_SON_WARN:   prdata = servo_on_deviation_threshold_reg;
        `MTL_OFF_TORQUE_LIM: prdata = {16'h0000, torque_limit_reg};
        `MTL_OFF_GAIN:       prdata = {16'h0000, position_loop_gain_reg};
        `MTL_OFF_GEAR_NUM:   prdata = {16'h0000, gear_ratio_numerator_reg};
        `MTL_OFF_GEAR_DEN:   prdata = {16'h0000, gear_ratio_denominator_reg};
        `MTL_OFF_TURNS:      prdata = {{16{turns[15]}}, turns};
        `MTL_OFF_DEVIATION:  prdata = deviation;
        `MTL_OFF_EXPECTED:   prdata = expected_reg;
        `MTL_OFF_IRQ_STATUS: prdata = {29'h00000000, irq_status_reg};
        `MTL_OFF_IRQ_MASK:   prdata = {29'h00000000, irq_mask_reg};
        `MTL_OFF_STATE:      prdata = {29'h00000000, abs_sync, limit_active, fault_reg};
        default:             prdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // motor drive, torque clamp, feedback outputs
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      servo_on_d_reg          <= 1'b0;
      fault_reg               <= 1'b0;
      motor_enable            <= 1'b0;
      torque_out              <= 16'h0000;
      multiturn_count_monitor <= 16'h0000;
      position_feedback       <= 32'h00000000;
      expected_reg            <= 32'h00000000;
    end
    else
    begin
      servo_on_d_reg <= servo_on_req;
      expected_reg   <= exp_quot[31:0];
      // fault latches until servo is dropped
      if (dev_event || son_event)
        fault_reg <= 1'b1;
      else if (!servo_on_req)
        fault_reg <= 1'b0;
      motor_enable <= servo_on_req && !fault_reg && !dev_event && !son_event;
      if (!motor_enable)
        torque_out <= 16'h0000;
      else if (torque_request > torque_limit_reg)
        torque_out <= torque_limit_reg;
      else
        torque_out <= torque_request;
      multiturn_count_monitor <= turns;
      if (position_feedback_cycle_select && limit_active)
        position_feedback <= accum;
      else
        position_feedback <= {{16{turns[15]}}, turns};
    end
  end

endmodule

`default_nettype wire

// [testbench/mtl_enc_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// encoder turn source
// ------------------------------
module mtl_enc_model
(
  input  wire logic pclk,
  input  wire logic abs_sel,
  output var  logic step_fwd,
  output var  logic step_rev,
  output wire logic absolute
);
  assign absolute = abs_sel;
  initial
  begin
    step_fwd = 1'h0;
    step_rev = 1'h0;
  end
  // one level per turn; never both directions at once
  task automatic turn(input logic fwd, input int n);
    repeat (n)
    begin
      step_fwd <= fwd;
      step_rev <= !fwd;
      @(posedge pclk);
    end
    step_fwd <= 1'h0;
    step_rev <= 1'h0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// [testbench/mtl_tracker_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// port checks
// ------------------------------
module mtl_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] cmd_position,
  input wire logic [31:0] act_position,
  input wire logic        position_control,
  input wire logic        servo_on_req,
  input wire logic        motor_enable,
  input wire logic [15:0] torque_out,
  input wire logic [15:0] multiturn_count_monitor
);
  logic        wr, cfg_en;
  logic [15:0] tlim_reg, tlim_old;
  logic [31:0] dthr_reg, sthr_reg, dv, adv;
  assign wr  = psel && penable && pwrite && pready;
  assign dv  = cmd_position - act_position;
  assign adv = dv[31] ? -dv : dv;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadows; the old limit covers the one-cycle lag of the clamp
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_en   <= 1'h0;
      tlim_reg <= 16'h7FFF;
      tlim_old <= 16'h7FFF;
      dthr_reg <= 32'h7FFFFFFF;
      sthr_reg <= 32'h7FFFFFFF;
    end
    else
    begin
      tlim_old <= tlim_reg;
      if (wr && paddr == 12'h004) cfg_en <= pwdata[0];
      if (wr && paddr == 12'h014) tlim_reg <= pwdata[15:0];
      if (wr && paddr == 12'h00C) dthr_reg <= pwdata;
      if (wr && paddr == 12'h010) sthr_reg <= pwdata;
    end
  chk_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_err_unmapped: assert property (psel && penable |->
    pslverr == (paddr > 12'h038 || paddr[1:0] != 2'h0)) else $error("pslverr wrong");
  chk_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read");
  chk_limit_range: assert property (
    psel && penable && !pwrite && paddr == 12'h000 |-> prdata <= 32'h00007530)
    else $error("revolution limit above range");
  chk_torque_clamp: assert property (
    torque_out <= tlim_reg || torque_out <= tlim_old) else $error("torque above limit");
  chk_signed_wrap: assert property (
    !cfg_en && $past(multiturn_count_monitor) == 16'h7FFF && multiturn_count_monitor != 16'h7FFF
    |-> multiturn_count_monitor inside {16'h8000, 16'h7FFE, 16'h0000})
    else $error("turn count did not wrap to negative end");
  chk_dev_stop: assert property (
    position_control && motor_enable && adv > dthr_reg |-> ##[1:6] !motor_enable)
    else $error("motor not stopped on deviation");
  chk_servo_on_dev: assert property (
    servo_on_req && !$past(servo_on_req) && adv > sthr_reg |-> ##[1:6] !motor_enable)
    else $error("servo-on deviation not refused");
endmodule
bind mtl_tracker mtl_chk u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_position(cmd_position), .act_position(act_position),
  .position_control(position_control), .servo_on_req(servo_on_req),
  .motor_enable(motor_enable), .torque_out(torque_out),
  .multiturn_count_monitor(multiturn_count_monitor)
);
`default_nettype wire

// [testbench/mtl_tracker_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// tracker bench
// ------------------------------
module mtl_tracker_bench;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x;} mtl_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        position_control, servo_on_req, motor_enable, irq, abs_sel;
  logic        enc_fwd, enc_rev, enc_abs;
  logic [11:0] paddr;
  logic [15:0] rpm, res, treq, torque_out, mon;
  logic [31:0] pwdata, prdata, rdat, cmd_position, act_position, pos_fb;
  int          miscompares, cmp_count;
  mtl_row_t    rows [14] = '{
    '{1'h0, 12'h000, 32'h0, 32'h0},
    '{1'h0, 12'h004, 32'h0, 32'h0},
    '{1'h0, 12'h00C, 32'h0, 32'h7FFFFFFF},
    '{1'h0, 12'h010, 32'h0, 32'h7FFFFFFF},
    '{1'h0, 12'h014, 32'h0, 32'h7FFF},
    '{1'h0, 12'h018, 32'h0, 32'h1},
    '{1'h0, 12'h030, 32'h0, 32'h0},
    '{1'h0, 12'h034, 32'h0, 32'h0},
    '{1'h1, 12'h000, 32'h7530, 32'h7530},
    '{1'h1, 12'h000, 32'h7531, 32'h7530},
    '{1'h1, 12'h014, 32'h100, 32'h100},
    '{1'h1, 12'h018, 32'hA, 32'hA},
    '{1'h1, 12'h01C, 32'h2, 32'h2},
    '{1'h1, 12'h020, 32'h1, 32'h1}};
  mtl_tracker dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_absolute(enc_abs), .enc_step_fwd(enc_fwd), .enc_step_rev(enc_rev),
    .cmd_position(cmd_position), .act_position(act_position), .motor_speed_rpm(rpm),
    .encoder_resolution(res), .position_control(position_control),
    .servo_on_req(servo_on_req), .torque_request(treq), .torque_out(torque_out),
    .multiturn_count_monitor(mon), .position_feedback(pos_fb),
    .motor_enable(motor_enable), .irq(irq)
  );
  mtl_enc_model enc
  (
    .pclk(pclk), .abs_sel(abs_sel), .step_fwd(enc_fwd), .step_rev(enc_rev), .absolute(enc_abs)
  );
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic results;
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  // idle edge at the end keeps back-to-back calls from double assigning psel
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic spin(input logic f, input int n);
    enc.turn(f, n);
    repeat (6) @(posedge pclk);
  endtask
  initial
  begin
    #600000;
    miscompares++;
    results();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, position_control, servo_on_req} = '0;
    {paddr, pwdata, treq, cmd_position, act_position} = '0;
    rpm = 16'h0258;
    res = 16'h03E8;
    abs_sel = 1'h1;
    repeat (12) @(posedge pclk);
    cmp({torque_out, mon}, 32'h0);
    cmp({pos_fb[29:0], motor_enable, irq}, 32'h0);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      cmp(rdat, rows[i].x);
    end
    apb(1'h0, 12'h100, 32'h0);
    cmp(rerr, 32'h1);
    treq <= 16'h0200;
    servo_on_req <= 1'h1;
    repeat (3) @(posedge pclk);
    cmp(torque_out, 32'h100);
    treq <= 16'h0050;
    cmd_position <= 32'h64;
    act_position <= 32'h28;
    repeat (3) @(posedge pclk);
    cmp(torque_out, 32'h50);
    servo_on_req <= 1'h0;
    apb(1'h0, 12'h028, 32'h0);
    cmp(rdat, 32'h3C);
    apb(1'h0, 12'h02C, 32'h0);
    cmp(rdat, 32'h7D0);
    spin(1'h0, 1);
    cmp(mon, 32'hFFFF);
    spin(1'h1, 32769);
    cmp(mon, 32'h8000);
    apb(1'h1, 12'h000, 32'h5);
    apb(1'h1, 12'h004, 32'h1);
    apb(1'h1, 12'h008, 32'h1);
    spin(1'h1, 7);
    cmp(mon, 32'h2);
    cmp(irq, 32'h0);
    apb(1'h1, 12'h034, 32'h4);
    cmp(irq, 32'h1);
    apb(1'h1, 12'h030, 32'h4);
    cmp(irq, 32'h0);
    spin(1'h0, 3);
    cmp(mon, 32'h4);
    apb(1'h1, 12'h004, 32'h11);
    apb(1'h1, 12'h008, 32'h1);
    spin(1'h1, 7);
    cmp(pos_fb, 32'h7);
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h1, 12'h004, 32'h1);
    apb(1'h1, 12'h008, 32'h1);
    spin(1'h1, 7);
    cmp(mon, 32'h7);
    abs_sel <= 1'h0;
    apb(1'h1, 12'h000, 32'h5);
    apb(1'h1, 12'h008, 32'h1);
    spin(1'h1, 7);
    cmp(mon, 32'h7);
    abs_sel <= 1'h1;
    act_position <= 32'h64;
    apb(1'h1, 12'h00C, 32'h32);
    position_control <= 1'h1;
    servo_on_req <= 1'h1;
    repeat (4) @(posedge pclk);
    cmp(motor_enable, 32'h1);
    act_position <= 32'h28;
    repeat (7) @(posedge pclk);
    cmp(motor_enable, 32'h0);
    apb(1'h0, 12'h030, 32'h0);
    cmp(rdat & 32'h1, 32'h1);
    servo_on_req <= 1'h0;
    apb(1'h1, 12'h00C, 32'h7FFFFFFF);
    apb(1'h1, 12'h010, 32'hA);
    servo_on_req <= 1'h1;
    repeat (7) @(posedge pclk);
    cmp(motor_enable, 32'h0);
    act_position <= 32'h64;
    servo_on_req <= 1'h0;
    repeat (3) @(posedge pclk);
    servo_on_req <= 1'h1;
    repeat (7) @(posedge pclk);
    cmp(motor_enable, 32'h1);
    results();
  end
endmodule
`default_nettype wire
